// *** rtl/cpcc_cfg.svh ***
// How it works
// - combined mode runs loops three and four together
// - combined mode: fourth-loop commands NAK, raise CML
// - balancing runs only with enable bit set
// - read-only saturation bit, zero when balanced
// - combined mode halves third-loop limits per phase
// - external drive compares against housekeeping ADC current
// - ADC code is 10 bits, 700 mV full scale
// - external sense gain selectable from 10x to 50x
// - programmable amps-per-code scale, LSB 0.976 mA
// - external drive: PWM out drives stage, switch unused
// - image count 0 or 1 means one file
// - each programming uses one of 20 segments
`ifndef CPCC_CFG_SVH
`define CPCC_CFG_SVH

// register byte offsets
`define OFF_MODE       8'h00
`define OFF_GAIN       8'h04
`define OFF_SCALE      8'h08
`define OFF_WARN_A     8'h0C
`define OFF_FAULT_A    8'h10
`define OFF_WARN_C     8'h14
`define OFF_FAULT_C    8'h18
`define OFF_IOUT_A     8'h1C
`define OFF_IRQ_STAT   8'h20
`define OFF_IRQ_MASK   8'h24
`define OFF_PBAL_CTRL  8'h28
`define OFF_NVM        8'h2C
`define OFF_PBAL_STAT  8'h50

// field positions
`define MODE_COMB_BIT  0
`define MODE_EXT_BIT   1
`define PBAL_EN_BIT    14
`define PBAL_SAT_BIT   13
`define NVM_PROG_BIT   8
`define NVM_SEG_LSB    16

// interrupt bits
`define IRQ_WARN_A     0
`define IRQ_FAULT_A    1
`define IRQ_WARN_C     2
`define IRQ_FAULT_C    3
`define IRQ_CML        4
`define IRQ_BAL_SAT    5
`define IRQ_NVM_FULL   6
`define IRQ_W          7

// converter and scale figures
`define ADC_W          10
`define ADC_FS_MV      700
`define SCALE_LSB_UA   976
`define SCALE_RST      16'h007D
`define GAIN_MIN       6'h0A
`define GAIN_MAX       6'h32
`define CUR_W          26

// configuration memory
`define SEG_TOTAL      5'h14
`define IMG_MAX        4'hF

// balancer
`define TRIM_MAX       8'sh7F
`define TRIM_MIN       -8'sh7F
`define BAL_DEADBAND   26'h0000010

// pmbus loop index of the fourth loop
`define LOOP_FOURTH    3'h3

`endif

// *** rtl/cpcc_pkg.sv ***
`include "cpcc_cfg.svh"
`default_nettype none
package cpcc_pkg;
  typedef logic [`CUR_W-1:0] cur_t;    // current in scale-LSB units
  typedef logic signed [7:0] trim_t;   // phase trim
  typedef logic [`ADC_W-1:0] adc_t;    // housekeeping adc code
  typedef logic [`IRQ_W-1:0] irq_t;    // interrupt vector
endpackage
`default_nettype wire

// *** rtl/bal_if.sv ***
`default_nettype none
// link between the controller and the phase balancer
interface bal_if;
  import cpcc_pkg::*;
  logic  en;      // balancing allowed
  logic  sample;  // new phase readings present
  cur_t  i_c;     // third-loop phase current
  cur_t  i_d;     // fourth-loop phase current
  trim_t trim;    // correction applied to phase c
  logic  sat;     // trim pinned at a limit
  modport ctrl (output en, output sample, output i_c, output i_d,
                input trim, input sat);
  modport bal  (input en, input sample, input i_c, input i_d,
                output trim, output sat);
endinterface
`default_nettype wire

// *** rtl/phase_balancer.sv ***
`include "cpcc_cfg.svh"
`default_nettype none
// nudges a trim toward equal phase currents, one step per sample
module phase_balancer
  import cpcc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  bal_if.bal        bal
);
  trim_t trim_reg;   // current trim
  trim_t trim_next;
  logic  sat_reg;    // saturation flag
  logic  sat_next;
  logic  c_high;     // phase c above d beyond deadband
  logic  d_high;     // phase d above c beyond deadband

  // step logic
  always_comb begin
    c_high    = bal.i_c > (bal.i_d + `BAL_DEADBAND);
    d_high    = bal.i_d > (bal.i_c + `BAL_DEADBAND);
    trim_next = trim_reg;
    sat_next  = sat_reg;
    if (!bal.en) begin
      // idle: trim released, not saturated
      trim_next = 8'sh00;
      sat_next  = 1'b0;
    end else if (bal.sample) begin
      sat_next = 1'b0;
      if (c_high) begin
        if (trim_reg == `TRIM_MIN) sat_next = 1'b1;
        else trim_next = trim_reg - 8'sh01;
      end else if (d_high) begin
        if (trim_reg == `TRIM_MAX) sat_next = 1'b1;
        else trim_next = trim_reg + 8'sh01;
      end
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_reg <= 8'sh00;
      sat_reg  <= 1'b0;
    end else begin
      trim_reg <= trim_next;
      sat_reg  <= sat_next;
    end
  end

  assign bal.trim = trim_reg;
  assign bal.sat  = sat_reg;
endmodule
`default_nettype wire

// *** rtl/combined_phase_current_control.sv ***
// Added by the designer: register access over APB.
`include "cpcc_cfg.svh"
`default_nettype none
// control of external drive, combined two-phase loop and config count
module combined_phase_current_control
  import cpcc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // pmbus command decode
  input  wire logic          cmd_valid,
  input  wire logic [2:0]    cmd_loop,
  output logic               cmd_nak,
  // housekeeping adc
  input  wire logic          adc_valid,
  input  wire cpcc_pkg::adc_t adc_code,
  // internal sensing
  input  wire cpcc_pkg::cur_t isense_a,
  input  wire cpcc_pkg::cur_t isense_c,
  input  wire cpcc_pkg::cur_t isense_d,
  input  wire logic          phase_sample,
  // first-loop modulator and pins
  input  wire logic          pwm_a_mod,
  output logic               pwm_a,
  output logic               switch_a_en,
  output logic      [5:0]    ecs_gain,
  // combined-loop outputs and overcurrent fault pins a, c, d
  output logic               loop_d_slaved,
  output cpcc_pkg::trim_t    phase_trim,
  output logic               oc_fault_a,
  output logic               oc_fault_c,
  output logic               oc_fault_d,
  // configuration memory and interrupt
  output logic               nvm_program,
  output logic      [3:0]    image_count,
  output logic               irq
);
  import cpcc_pkg::*;

  bal_if bal ();  // balancer link

  // software registers
  logic [1:0]  mode_reg,    mode_next;     // combined, external drive
  logic [5:0]  gain_reg,    gain_next;     // sense amp gain
  logic [15:0] scale_reg,   scale_next;    // ma per code in lsb units
  cur_t        warn_a_reg,  warn_a_next;   // first-loop warn limit
  cur_t        fault_a_reg, fault_a_next;  // first-loop fault limit
  cur_t        warn_c_reg,  warn_c_next;   // third-loop warn limit
  cur_t        fault_c_reg, fault_c_next;  // third-loop fault limit
  logic [15:0] pbal_reg,    pbal_next;     // balance control word
  logic [3:0]  img_reg,     img_next;      // config image count
  logic [4:0]  seg_reg,     seg_next;      // segments used
  irq_t        stat_reg,    stat_next;     // sticky events
  irq_t        mask_reg,    mask_next;     // event enables
  // block state
  cur_t        iout_a_reg,  iout_a_next;   // reported first-loop current
  logic [3:0]  lvl_reg,     lvl_next;      // warn/fault levels a, c
  logic        fd_reg,      fd_next;       // phase d fault level
  // port flops
  logic [31:0] prdata_reg,  prdata_next;
  logic        pready_reg,  pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        nak_reg,     nak_next;
  logic        pwm_reg,     pwm_next;
  logic        swen_reg,    swen_next;
  logic        prog_reg,    prog_next;
  logic        irq_reg,     irq_next;
  // combinational helpers
  logic        setup;       // apb setup cycle
  logic        wr;          // write completes this edge
  logic        known;       // address decodes
  logic [31:0] rdata;       // read mux
  irq_t        events;      // one-cycle event set
  irq_t        w1c;         // bits software clears
  logic        comb_m;      // combined mode
  logic        ext_m;       // external drive mode
  cur_t        adc_cur;     // adc code scaled to current
  cur_t        lim_wc;      // per-phase warn limit
  cur_t        lim_fc;      // per-phase fault limit
  logic [3:0]  lvl_now;     // warn a, fault a, warn c, fault c
  logic        fd_now;      // phase d over fault limit
  logic        wd_now;      // phase d over warn limit

  // balancer instance
  phase_balancer u_bal (
    .clk   (clk),
    .rst_n (rst_n),
    .bal   (bal.bal)
  );

  // balancer feeds
  assign bal.en     = mode_reg[`MODE_COMB_BIT]
                    & pbal_reg[`PBAL_EN_BIT];
  assign bal.sample = phase_sample;
  assign bal.i_c    = isense_c;
  assign bal.i_d    = isense_d;

  // next-state computation for all registers
  always_comb begin
    comb_m  = mode_reg[`MODE_COMB_BIT];
    ext_m   = mode_reg[`MODE_EXT_BIT];
    setup   = psel & ~penable;
    wr      = psel & penable & pready_reg & pwrite;
    // code times scale, in 0.976 ma units
    adc_cur = `CUR_W'({16'h0000, adc_code} * {10'h000, scale_reg});
    // per-phase limits, halved in combined mode
    lim_wc  = comb_m ? (warn_c_reg >> 1)  : warn_c_reg;
    lim_fc  = comb_m ? (fault_c_reg >> 1) : fault_c_reg;
    // first-loop comparisons use the reported current, phases c and d the sense inputs
    lvl_now[0] = iout_a_reg >= warn_a_reg;
    lvl_now[1] = iout_a_reg >= fault_a_reg;
    wd_now     = comb_m & (isense_d >= lim_wc);
    fd_now     = comb_m & (isense_d >= lim_fc);
    lvl_now[2] = (isense_c >= lim_wc) | wd_now;
    lvl_now[3] = (isense_c >= lim_fc) | fd_now;

    // address decode and read mux
    known = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      `OFF_MODE:      rdata = {30'h0, mode_reg};
      `OFF_GAIN:      rdata = {26'h0, gain_reg};
      `OFF_SCALE:     rdata = {16'h0, scale_reg};
      `OFF_WARN_A:    rdata = {6'h0, warn_a_reg};
      `OFF_FAULT_A:   rdata = {6'h0, fault_a_reg};
      `OFF_WARN_C:    rdata = {6'h0, warn_c_reg};
      `OFF_FAULT_C:   rdata = {6'h0, fault_c_reg};
      `OFF_IOUT_A:    rdata = {6'h0, iout_a_reg};
      `OFF_IRQ_STAT:  rdata = {25'h0, stat_reg};
      `OFF_IRQ_MASK:  rdata = {25'h0, mask_reg};
      `OFF_PBAL_CTRL: rdata = {16'h0, pbal_reg};
      `OFF_NVM:       rdata = {11'h0, seg_reg, 12'h0, img_reg};
      `OFF_PBAL_STAT: begin
        // saturation bit, read only
        rdata[`PBAL_SAT_BIT] = bal.sat;
      end
      default:        known = 1'b0;
    endcase

    // apb answer: ready in the first access cycle
    pready_next  = setup;
    pslverr_next = setup & ~known;
    prdata_next  = (setup & ~pwrite & known) ? rdata : 32'h0000_0000;

    // defaults hold; program pulse, clear set and event set start at zero
    mode_next    = mode_reg;
    gain_next    = gain_reg;
    scale_next   = scale_reg;
    warn_a_next  = warn_a_reg;
    fault_a_next = fault_a_reg;
    warn_c_next  = warn_c_reg;
    fault_c_next = fault_c_reg;
    pbal_next    = pbal_reg;
    img_next     = img_reg;
    seg_next     = seg_reg;
    mask_next    = mask_reg;
    prog_next    = 1'b0;
    w1c          = '0;
    events       = '0;

    // register writes
    if (wr && known) begin
      case (paddr)
        `OFF_MODE:      mode_next    = pwdata[1:0];
        `OFF_GAIN: begin
          // gain clamped to the allowed span
          if (pwdata[31:6] != 26'h0 || pwdata[5:0] > `GAIN_MAX)
            gain_next = `GAIN_MAX;
          else if (pwdata[5:0] < `GAIN_MIN)
            gain_next = `GAIN_MIN;
          else
            gain_next = pwdata[5:0];
        end
        `OFF_SCALE:     scale_next   = pwdata[15:0];
        `OFF_WARN_A:    warn_a_next  = pwdata[`CUR_W-1:0];
        `OFF_FAULT_A:   fault_a_next = pwdata[`CUR_W-1:0];
        `OFF_WARN_C:    warn_c_next  = pwdata[`CUR_W-1:0];
        `OFF_FAULT_C:   fault_c_next = pwdata[`CUR_W-1:0];
        `OFF_IRQ_STAT:  w1c          = pwdata[`IRQ_W-1:0];
        `OFF_IRQ_MASK:  mask_next    = pwdata[`IRQ_W-1:0];
        `OFF_PBAL_CTRL: pbal_next    = pwdata[15:0];
        `OFF_NVM: begin
          img_next = pwdata[3:0];
          // programming request takes one segment
          if (pwdata[`NVM_PROG_BIT]) begin
            if (seg_reg < `SEG_TOTAL) begin
              seg_next  = seg_reg + 5'h01;
              prog_next = 1'b1;
            end else begin
              events[`IRQ_NVM_FULL] = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    // reported current: adc in external drive, else internal
    iout_a_next = iout_a_reg;
    if (ext_m) begin
      if (adc_valid) iout_a_next = adc_cur;
    end else begin
      iout_a_next = isense_a;
    end

    // rising warn/fault levels become events
    lvl_next = lvl_now;
    fd_next  = fd_now;
    events[`IRQ_WARN_A]  = lvl_now[0] & ~lvl_reg[0];
    events[`IRQ_FAULT_A] = lvl_now[1] & ~lvl_reg[1];
    events[`IRQ_WARN_C]  = lvl_now[2] & ~lvl_reg[2];
    events[`IRQ_FAULT_C] = lvl_now[3] & ~lvl_reg[3];
    events[`IRQ_BAL_SAT] = bal.sat;

    // fourth-loop command while combined: nak and cml
    nak_next = cmd_valid & comb_m & (cmd_loop == `LOOP_FOURTH);
    events[`IRQ_CML] = nak_next;

    // sticky status, set wins over clear
    stat_next = (stat_reg & ~w1c) | events;
    irq_next  = |(stat_next & mask_next);

    // first-loop drive pins
    pwm_next  = pwm_a_mod;
    swen_next = ~ext_m;
  end

  // register bank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg    <= 2'h0;
      gain_reg    <= `GAIN_MIN;
      scale_reg   <= `SCALE_RST;
      warn_a_reg  <= {`CUR_W{1'b1}};
      fault_a_reg <= {`CUR_W{1'b1}};
      warn_c_reg  <= {`CUR_W{1'b1}};
      fault_c_reg <= {`CUR_W{1'b1}};
      pbal_reg    <= 16'h0000;
      img_reg     <= 4'h0;
      seg_reg     <= 5'h00;
      stat_reg    <= '0;
      mask_reg    <= '0;
      iout_a_reg  <= '0;
      lvl_reg     <= 4'h0;
      fd_reg      <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      nak_reg     <= 1'b0;
      pwm_reg     <= 1'b0;
      swen_reg    <= 1'b1;
      prog_reg    <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      gain_reg    <= gain_next;
      scale_reg   <= scale_next;
      warn_a_reg  <= warn_a_next;
      fault_a_reg <= fault_a_next;
      warn_c_reg  <= warn_c_next;
      fault_c_reg <= fault_c_next;
      pbal_reg    <= pbal_next;
      img_reg     <= img_next;
      seg_reg     <= seg_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
      iout_a_reg  <= iout_a_next;
      lvl_reg     <= lvl_next;
      fd_reg      <= fd_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      nak_reg     <= nak_next;
      pwm_reg     <= pwm_next;
      swen_reg    <= swen_next;
      prog_reg    <= prog_next;
      irq_reg     <= irq_next;
    end
  end

  // outputs straight from flops
  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign cmd_nak       = nak_reg;
  assign pwm_a         = pwm_reg;
  assign switch_a_en   = swen_reg;
  assign ecs_gain      = gain_reg;
  assign loop_d_slaved = mode_reg[`MODE_COMB_BIT];
  assign phase_trim    = bal.trim;
  assign oc_fault_a    = lvl_reg[1];
  assign oc_fault_c    = lvl_reg[3];
  assign oc_fault_d    = fd_reg;
  assign nvm_program   = prog_reg;
  // zero and one both mean a single stored image
  assign image_count   = img_reg;
  assign irq           = irq_reg;
endmodule
`default_nettype wire

// *** sim/adc_stage_model.sv ***
`default_nettype none
// external sense amplifier plus housekeeping converter, one code per request
module adc_stage_model
  import cpcc_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           req,
  input  wire logic           slow,
  input  wire cpcc_pkg::adc_t code_in,
  output logic                adc_valid,
  output cpcc_pkg::adc_t      adc_code
);
  adc_t       held;  // amplified reading waiting for conversion
  logic [1:0] wait_cnt;  // conversion delay when slow
  logic       busy;  // conversion in flight
  // one-cycle valid; the code line toggles outside that cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_valid <= 1'b0;
      adc_code  <= 10'h155;
      held      <= 10'h000;
      wait_cnt  <= 2'h0;
      busy      <= 1'b0;
    end else begin
      adc_valid <= 1'b0;
      adc_code  <= ~adc_code;
      if (req) begin
        // gained signal held as a 10-bit code
        held     <= code_in;
        busy     <= 1'b1;
        wait_cnt <= slow ? 2'h3 : 2'h0;
      end else if (busy && wait_cnt == 2'h0) begin
        adc_valid <= 1'b1;
        adc_code  <= held;
        busy      <= 1'b0;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/cpcc_chk.sv ***
`default_nettype none
// port-level checks of the combined-loop controller
module cpcc_chk
  import cpcc_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pready,
  input wire logic            cmd_valid,
  input wire logic [2:0]      cmd_loop,
  input wire logic            cmd_nak,
  input wire logic            pwm_a_mod,
  input wire logic            pwm_a,
  input wire logic [5:0]      ecs_gain,
  input wire logic            loop_d_slaved,
  input wire cpcc_pkg::trim_t phase_trim,
  input wire logic            nvm_program
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // fourth-loop command while combined
  sequence s_nak_req;
    cmd_valid && cmd_loop == 3'h3 && loop_d_slaved;
  endsequence
  // apb setup cycle
  sequence s_setup;
    psel && !penable;
  endsequence
  // combined mode off long enough for the trim to clear
  sequence s_unslaved;
    !loop_d_slaved [*4];
  endsequence
  nak_after_cmd_a: assert property (s_nak_req |=> cmd_nak)
    else $error("no nak after fourth-loop command");
  nak_cause_a: assert property (
    cmd_nak |-> $past(cmd_valid && cmd_loop == 3'h3 && loop_d_slaved))
    else $error("nak without cause");
  pwm_follow_a: assert property (1 |=> pwm_a == $past(pwm_a_mod))
    else $error("pwm output not following modulator");
  gain_range_a: assert property (
    ecs_gain >= 6'h0A && ecs_gain <= 6'h32)
    else $error("sense gain out of range");
  trim_idle_a: assert property (s_unslaved |-> phase_trim == 8'sh00)
    else $error("trim active outside combined mode");
  trim_limit_a: assert property (phase_trim != 8'sh80)
    else $error("trim beyond limit");
  nvm_pulse_a: assert property (nvm_program |=> !nvm_program)
    else $error("program pulse too long");
  ready_pulse_a: assert property (s_setup |=> pready ##1 !pready)
    else $error("apb ready not a single access cycle");
  nak_seen_c: cover property (s_nak_req ##1 cmd_nak);
endmodule
bind combined_phase_current_control cpcc_chk i_chk (
  .clk, .rst_n, .psel, .penable, .pready, .cmd_valid, .cmd_loop,
  .cmd_nak, .pwm_a_mod, .pwm_a, .ecs_gain, .loop_d_slaved,
  .phase_trim, .nvm_program);
`default_nettype wire

// *** sim/combined_phase_current_control_tb.sv ***
`default_nettype none
module combined_phase_current_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cpcc_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, cmd_valid, err;
  logic        req, slow, phase_sample, pwm_a_mod, pready, pslverr;
  logic        adc_valid, cmd_nak, pwm_a, switch_a_en, loop_d_slaved;
  logic        oc_a, oc_c, oc_d, nvm_program, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [2:0]  cmd_loop;
  logic [5:0]  ecs_gain;
  logic [3:0]  image_count;
  adc_t        code, adc_code;
  cur_t        isense_a, isense_c, isense_d;
  trim_t       phase_trim;
  int          miscompares, num_checks, cyc, pulses, i, c, sc;
  int          gt[3] = '{5, 33, 60};  // gain writes
  int          ge[3] = '{10, 33, 50};  // gains expected after clamp
  int          qc[3] = '{100, 99, 0};  // phase c currents
  int          qd[3] = '{0, 0, 100};  // phase d currents
  combined_phase_current_control i_dut (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_valid,
    .cmd_loop, .cmd_nak, .adc_valid, .adc_code, .isense_a, .isense_c,
    .isense_d, .phase_sample, .pwm_a_mod, .pwm_a, .switch_a_en,
    .ecs_gain, .loop_d_slaved, .phase_trim, .oc_fault_a(oc_a),
    .oc_fault_c(oc_c), .oc_fault_d(oc_d), .nvm_program, .image_count,
    .irq);
  adc_stage_model i_adc (.clk, .rst_n, .req, .slow, .code_in(code),
    .adc_valid, .adc_code);
  always #2 clk = ~clk;
  // hang guard and program pulse count
  always @(posedge clk) begin
    cyc++;
    if (nvm_program === 1'b1) pulses++;
    if (cyc == 30000) begin
      miscompares++;
      summarize();
    end
  end
  // random modulator level
  always @(posedge clk) pwm_a_mod <= 1'(rnd());
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task summarize();
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer, held until ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // wait for ready as long as it takes; the hang guard ends a stall
    do begin @(posedge clk); end while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0); chk(rd, e);
  endtask
  task st();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task cmd(input logic [2:0] l, input logic e);
    @(posedge clk); cmd_valid <= 1; cmd_loop <= l;
    @(posedge clk); cmd_valid <= 0;
    @(negedge clk); chk(cmd_nak, e);
  endtask
  task adc(input int v);
    @(posedge clk); req <= 1; code <= v[9:0]; slow <= seed[0];
    @(posedge clk); req <= 0;
    // wait for the conversion; the hang guard ends a stall
    do begin @(posedge clk); end while (adc_valid !== 1'b1);
    st();
  endtask
  task bal_steps(input int n);
    repeat (n) begin
      @(posedge clk); phase_sample <= 1;
      @(posedge clk); phase_sample <= 0;
    end
    st();
  endtask
  initial begin
    seed = 32'd24732; clk = 0; rst_n = 0; psel = 0; penable = 0;
    pwrite = 0; paddr = 0; pwdata = 0; cmd_valid = 0; cmd_loop = 0;
    req = 0; slow = 0; code = 0; phase_sample = 0; pwm_a_mod = 0;
    isense_a = 0; isense_c = 0; isense_d = 0;
    miscompares = 0; num_checks = 0; cyc = 0; pulses = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    rdc(8'h08, 32'h7D);
    chk(ecs_gain, 6'h0A);
    rdc(8'h40, 0); chk(err, 1);
    for (i = 0; i < 3; i++) begin
      apb(1, 8'h04, gt[i]); st(); chk(ecs_gain, ge[i]);
    end
    // external drive: reported current is code times scale
    apb(1, 8'h00, 2); st(); chk(switch_a_en, 0);
    for (i = 0; i < 6; i++) begin
      sc = rnd() & 16'hFFFF;
      c = (i == 0) ? 10'h3FF : rnd() & 10'h3FF;
      apb(1, 8'h08, sc); adc(c);
      rdc(8'h1C, (c * sc) & 26'h3FFFFFF);
    end
    // fault a tripped by the converter only, at the exact limit
    // bring the reported current below the limit before arming it
    apb(1, 8'h08, 32'h7D); adc(299);
    apb(1, 8'h24, 32'h2); apb(1, 8'h10, 37500);
    @(posedge clk); isense_a <= '1;
    adc(299); chk(oc_a, 0); chk(irq, 0);
    adc(300); chk(oc_a, 1); chk(irq, 1);
    @(posedge clk); isense_a <= '0;
    rdc(8'h20, 32'h2); apb(1, 8'h20, 32'h2); st();
    rdc(8'h20, 0); chk(irq, 0);
    // combined loops
    apb(1, 8'h00, 1); st(); chk(loop_d_slaved, 1);
    chk(switch_a_en, 1);
    cmd(3, 1); cmd(2, 0); cmd(3, 1);
    rdc(8'h20, 32'h10);
    apb(1, 8'h18, 200);
    for (i = 0; i < 3; i++) begin
      @(posedge clk); isense_c <= qc[i]; isense_d <= qd[i];
      // combined fault level covers both phases, d has its own pin
      st(); chk(oc_c, i != 1); chk(oc_d, i == 2);
    end
    // warn limit halved too: 2000 trips at 1000, not at 999
    apb(1, 8'h14, 2000); @(posedge clk); isense_c <= 999; st();
    rdc(8'h20, 32'h18);
    @(posedge clk); isense_c <= 1000; st();
    rdc(8'h20, 32'h1C);
    // balancing pinned, then balanced, then disabled
    apb(1, 8'h28, 32'h4000); rdc(8'h28, 32'h4000);
    @(posedge clk); isense_c <= 1000; isense_d <= 0;
    bal_steps(200);
    chk(phase_trim === 8'sh7F || phase_trim === 8'sh81, 1);
    rdc(8'h50, 32'h2000);
    @(posedge clk); isense_d <= 1000;
    bal_steps(2); rdc(8'h50, 0);
    apb(1, 8'h50, 32'hFFFF); rdc(8'h50, 0);
    apb(1, 8'h28, 0); st(); chk(phase_trim, 0);
    @(posedge clk); isense_d <= 0;
    bal_steps(4); chk(phase_trim, 0);
    // programming uses up the twenty segments
    for (i = 0; i < 21; i++) apb(1, 8'h2C, 32'h101);
    st(); chk(pulses, 20);
    rdc(8'h2C, 32'h140001); chk(image_count, 1);
    apb(0, 8'h20, 0); chk(rd[6], 1);
    apb(1, 8'h2C, 0); st(); chk(image_count, 0);
    summarize();
  end
endmodule
`default_nettype wire
